//--- rtl/cpcs_top.sv
// card pin control and state register with axi4-lite slave and interrupt
// Overview of operation
// - bit 30 reads 1 while the last write is still synchronising, else 0
// - bit 16 shows the sampled level of the card data pin
// - power pin equals invert bit 11 xor power drive bit 0, and invert bit 11 alone during deactivation
// - with edge select 0 a falling detect edge means card inserted
// - pin control register sits at offset 0x24, resets to zero
// - with edge select 1 a rising detect edge means card inserted
// - bit 9 drives the data output level, hardware overrides during deactivation
// - auto deactivation on removal runs deactivation then raises an end interrupt
`include "cpcs_cfg.svh"
`timescale 1ns/10ps
module cpcs_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic card_io_pin,
   input wire logic card_detect_pin,
   output logic card_power_pin,
   output logic card_io_out_level,
   output logic card_clk_enable,
   output logic card_reset_level,
   output logic irq
);
   localparam logic [3:0] SYNC_CYC = 4'(`CPCS_SYNC_CYC);
   localparam logic [7:0] DEACT_CYC = 8'(`CPCS_DEACT_CYC);
   typedef struct packed {
      cpcs_pkg::cpcs_bus_type bus;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [11:0] ctrl;
      logic [3:0] sync_cnt;
      logic cd_prev;
      logic ins_f;
      logic rem_f;
      logic [2:0] ist;
      logic [2:0] imask;
      cpcs_pkg::cpcs_seq_type seq;
      logic [7:0] seq_cnt;
      logic pow;
      logic io_out;
      logic clk_en;
      logic rst_lv;
      logic irq;
      logic awready;
      logic wready;
      logic arready;
   } cpcs_state_type;
   cpcs_state_type st_ff;
   cpcs_state_type nxt_st;
   logic io_sync;
   logic cd_sync;

   cpcs_sync2 u_io_sync (
      .clk(clk),
      .nrst(nrst),
      .d(card_io_pin),
      .q(io_sync)
   );
   cpcs_sync2 u_cd_sync (
      .clk(clk),
      .nrst(nrst),
      .d(card_detect_pin),
      .q(cd_sync)
   );

   function automatic logic [31:0] pin_reg_view(input logic [11:0] c, input logic busy, input logic io,
      input logic cd, input logic ins, input logic rem);
      logic [31:0] v;
      v = 32'h00000000;
      v[11:6] = c[11:6];
      v[1:0] = c[1:0];
      v[`CPCS_BIT_SYNC] = busy;
      v[`CPCS_BIT_IO_LEVEL] = io;
      v[`CPCS_BIT_OEN_ST] = 1'b1;
      v[`CPCS_BIT_CD_LEVEL] = cd;
      v[`CPCS_BIT_INS_F] = ins;
      v[`CPCS_BIT_REM_F] = rem;
      return v;
   endfunction

   always_comb
   begin
      logic [31:0] m;
      logic [31:0] wv;
      logic do_wr;
      logic do_rd;
      logic rise;
      logic fall;
      logic ins_ev;
      logic rem_ev;
      logic [2:0] set;
      m = 32'h00000000;
      wv = 32'h00000000;
      do_wr = 1'b0;
      do_rd = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      ins_ev = 1'b0;
      rem_ev = 1'b0;
      set = 3'b000;
      nxt_st = st_ff;
      rise = cd_sync & ~st_ff.cd_prev;
      fall = ~cd_sync & st_ff.cd_prev;
      nxt_st.cd_prev = cd_sync;
      ins_ev = st_ff.ctrl[`CPCS_BIT_EDGE_SEL] ? rise : fall;
      rem_ev = st_ff.ctrl[`CPCS_BIT_EDGE_SEL] ? fall : rise;
      set = 3'b000;
      if (st_ff.sync_cnt != 4'h0)
         nxt_st.sync_cnt = st_ff.sync_cnt - 4'h1;
      nxt_st.awready = 1'b0;
      nxt_st.wready = 1'b0;
      nxt_st.arready = 1'b0;
      case (st_ff.bus)
         cpcs_pkg::cpcs_idle:
         begin
            if (s_axi_awvalid && !st_ff.aw_got && !st_ff.awready)
            begin
               nxt_st.aw_got = 1'b1;
               nxt_st.awaddr = s_axi_awaddr;
               nxt_st.awready = 1'b1;
            end
            if (s_axi_wvalid && !st_ff.w_got && !st_ff.wready)
            begin
               nxt_st.w_got = 1'b1;
               nxt_st.wdata = s_axi_wdata;
               nxt_st.wstrb = s_axi_wstrb;
               nxt_st.wready = 1'b1;
            end
            if (st_ff.aw_got && st_ff.w_got)
               do_wr = 1'b1;
            else if (s_axi_arvalid && !st_ff.arready && !st_ff.aw_got && !st_ff.w_got)
               do_rd = 1'b1;
         end
         cpcs_pkg::cpcs_rdata:
            if (s_axi_rready)
               nxt_st.bus = cpcs_pkg::cpcs_idle;
         cpcs_pkg::cpcs_bresp:
            if (s_axi_bready)
               nxt_st.bus = cpcs_pkg::cpcs_idle;
         default:
            nxt_st.bus = cpcs_pkg::cpcs_idle;
      endcase
      if (do_wr)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bus = cpcs_pkg::cpcs_bresp;
         nxt_st.resp = 2'b00;
         for (int i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{st_ff.wstrb[i]}};
         wv = (st_ff.wdata & m) | ({20'h00000, st_ff.ctrl} & ~m);
         case (st_ff.awaddr & 8'hfc)
            `CPCS_PIN_CTRL_OFS:
            begin
               nxt_st.ctrl = wv[11:0] & 12'(`CPCS_WR_MASK);
               nxt_st.sync_cnt = SYNC_CYC;
            end
            `CPCS_IRQ_MASK_OFS:
               if (st_ff.wstrb[0])
                  nxt_st.imask = st_ff.wdata[2:0];
            `CPCS_IRQ_STAT_OFS, `CPCS_STATUS_OFS:
               nxt_st.resp = 2'b00;
            default:
               nxt_st.resp = 2'b10;
         endcase
      end
      if (do_rd)
      begin
         nxt_st.arready = 1'b1;
         nxt_st.bus = cpcs_pkg::cpcs_rdata;
         nxt_st.resp = 2'b00;
         case (s_axi_araddr & 8'hfc)
            `CPCS_PIN_CTRL_OFS:
            begin
               nxt_st.rdata = pin_reg_view(st_ff.ctrl, st_ff.sync_cnt != 4'h0, io_sync, cd_sync, st_ff.ins_f,
                  st_ff.rem_f);
               nxt_st.ins_f = 1'b0;
               nxt_st.rem_f = 1'b0;
            end
            `CPCS_IRQ_STAT_OFS:
            begin
               nxt_st.rdata = {29'h0, st_ff.ist};
               nxt_st.ist = 3'b000;
            end
            `CPCS_IRQ_MASK_OFS:
               nxt_st.rdata = {29'h0, st_ff.imask};
            `CPCS_STATUS_OFS:
               nxt_st.rdata = {30'h0, st_ff.seq};
            default:
            begin
               nxt_st.rdata = 32'h00000000;
               nxt_st.resp = 2'b10;
            end
         endcase
      end
      // deactivation on removal
      case (st_ff.seq)
         cpcs_pkg::cpcs_run:
            if (rem_ev && st_ff.ctrl[`CPCS_BIT_AUTO_DEACT])
            begin
               nxt_st.seq = cpcs_pkg::cpcs_deact;
               nxt_st.seq_cnt = DEACT_CYC;
            end
         cpcs_pkg::cpcs_deact:
            if (st_ff.seq_cnt == 8'h00)
            begin
               nxt_st.seq = cpcs_pkg::cpcs_run;
               nxt_st.ctrl[`CPCS_BIT_POW_DRV] = 1'b0;
               nxt_st.ctrl[`CPCS_BIT_CLK_KEEP] = 1'b0;
               nxt_st.ctrl[`CPCS_BIT_IO_OUT] = 1'b0;
               nxt_st.ctrl[`CPCS_BIT_CARD_RST] = 1'b0;
               set[2] = 1'b1;
            end
            else
               nxt_st.seq_cnt = st_ff.seq_cnt - 8'h01;
         default:
            nxt_st.seq = cpcs_pkg::cpcs_run;
      endcase
      set[0] = ins_ev;
      set[1] = rem_ev;
      if (ins_ev)
         nxt_st.ins_f = 1'b1;
      if (rem_ev)
         nxt_st.rem_f = 1'b1;
      nxt_st.ist = nxt_st.ist | set;
      // deactivation overrides software levels on the pins
      if (st_ff.seq == cpcs_pkg::cpcs_deact)
      begin
         nxt_st.pow = st_ff.ctrl[`CPCS_BIT_POWER_PIN_INVERT];
         nxt_st.io_out = 1'b0;
         nxt_st.clk_en = 1'b0;
         nxt_st.rst_lv = 1'b0;
      end
      else
      begin
         nxt_st.pow = st_ff.ctrl[`CPCS_BIT_POWER_PIN_INVERT] ^ st_ff.ctrl[`CPCS_BIT_POW_DRV];
         nxt_st.io_out = st_ff.ctrl[`CPCS_BIT_IO_OUT];
         nxt_st.clk_en = st_ff.ctrl[`CPCS_BIT_CLK_KEEP];
         nxt_st.rst_lv = st_ff.ctrl[`CPCS_BIT_CARD_RST];
      end
      nxt_st.irq = |(st_ff.ist & st_ff.imask);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_bvalid = st_ff.bus == cpcs_pkg::cpcs_bresp;
   assign s_axi_bresp = st_ff.resp;
   assign s_axi_rvalid = st_ff.bus == cpcs_pkg::cpcs_rdata;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.resp;
   assign card_power_pin = st_ff.pow;
   assign card_io_out_level = st_ff.io_out;
   assign card_clk_enable = st_ff.clk_en;
   assign card_reset_level = st_ff.rst_lv;
   assign irq = st_ff.irq;

   sync_after_write_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff.bus == cpcs_pkg::cpcs_bresp && $past(st_ff.bus) == cpcs_pkg::cpcs_idle && $past(st_ff.awaddr[7:2]) == 6'h09)
      |-> st_ff.sync_cnt == SYNC_CYC)
      else $error("sync count not loaded after pin register write");
   power_pin_xor_a: assert property (@(posedge clk) disable iff (!nrst)
      st_ff.seq != cpcs_pkg::cpcs_deact && $past(st_ff.seq) != cpcs_pkg::cpcs_deact
      |-> card_power_pin == ($past(st_ff.ctrl[11]) ^ $past(st_ff.ctrl[0])))
      else $error("power pin not invert xor drive");
   insert_fall_a: assert property (@(posedge clk) disable iff (!nrst)
      (!st_ff.ctrl[10] && st_ff.cd_prev && !cd_sync) |=> st_ff.ins_f && st_ff.ist[0])
      else $error("falling detect edge not flagged as insert");
   insert_rise_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff.ctrl[10] && !st_ff.cd_prev && cd_sync) |=> st_ff.ins_f && st_ff.ist[0])
      else $error("rising detect edge not flagged as insert");
   io_out_follow_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff.seq == cpcs_pkg::cpcs_run && st_ff.ctrl[9]) [*2] |=> card_io_out_level)
      else $error("data output does not follow bit 9");
   deact_end_irq_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(st_ff.seq == cpcs_pkg::cpcs_deact) |-> ##[1:20] st_ff.ist[2])
      else $error("deactivation did not raise end interrupt");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!nrst)
      (st_ff.ctrl & ~12'(`CPCS_WR_MASK)) == 12'h000)
      else $error("reserved control bit set");
   pin_reg_view_a: assert property (@(posedge clk) disable iff (!nrst)
      s_axi_rvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h09
      |-> s_axi_rdata[31] == 1'b0 && s_axi_rdata[29:17] == 13'h0000 && s_axi_rdata[15:12] == 4'h0
      && s_axi_rdata[5] == 1'b0)
      else $error("reserved bits of pin register read nonzero");
   pin_level_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(s_axi_rvalid) && $past(s_axi_araddr[7:2]) == 6'h09 |-> s_axi_rdata[16] == $past(io_sync))
      else $error("data pin level not reported in bit 16");
endmodule

//--- rtl/cpcs_cfg.svh
// offsets, field positions, reset values and timing counts of the card pin control block
`ifndef CPCS_CFG_SVH
`define CPCS_CFG_SVH
`define CPCS_PIN_CTRL_OFS 8'h24
`define CPCS_IRQ_STAT_OFS 8'h28
`define CPCS_IRQ_MASK_OFS 8'h2c
`define CPCS_STATUS_OFS 8'h30
`define CPCS_BIT_SYNC 30
`define CPCS_BIT_IO_LEVEL 16
`define CPCS_BIT_POWER_PIN_INVERT 11
`define CPCS_BIT_EDGE_SEL 10
`define CPCS_BIT_IO_OUT 9
`define CPCS_BIT_OEN_ST 8
`define CPCS_BIT_AUTO_DEACT 7
`define CPCS_BIT_CLK_KEEP 6
`define CPCS_BIT_CD_LEVEL 4
`define CPCS_BIT_INS_F 3
`define CPCS_BIT_REM_F 2
`define CPCS_BIT_CARD_RST 1
`define CPCS_BIT_POW_DRV 0
`define CPCS_WR_MASK 32'h00000ec3
`define CPCS_RESET_VAL 32'h00000000
`define CPCS_SYNC_NS 300
`define CPCS_CLK_NS 100
`define CPCS_SYNC_CYC ((`CPCS_SYNC_NS + `CPCS_CLK_NS - 1) / `CPCS_CLK_NS)
`define CPCS_DEACT_NS 1000
`define CPCS_DEACT_CYC (`CPCS_DEACT_NS / `CPCS_CLK_NS)
`endif

//--- rtl/cpcs_pkg.sv
// types of the card pin control block
package cpcs_pkg;
   typedef enum logic [1:0] {cpcs_idle, cpcs_rdata, cpcs_bresp} cpcs_bus_type;
   typedef enum logic [1:0] {cpcs_run, cpcs_deact, cpcs_done} cpcs_seq_type;
endpackage

//--- rtl/cpcs_sync2.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/10ps
module cpcs_sync2 (
   input wire logic clk,
   input wire logic nrst,
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic meta;
      logic q;
   } cpcs_sync_type;
   cpcs_sync_type st_ff;
   cpcs_sync_type nxt_st;
   always_comb
   begin
      nxt_st.meta = d;
      nxt_st.q = st_ff.meta;
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign q = st_ff.q;
endmodule

//--- dv/cpcs_card_model.sv
// behavioural smart card data line and card detect switch
`timescale 1ns/10ps
module cpcs_card_model (
   input wire logic clk,
   input wire logic inserted,
   input wire logic io_want,
   input wire logic hi_ins,
   output logic card_io_pin,
   output logic card_detect_pin
);
   // switch level shows presence in the polarity the bench selects
   always_ff @(posedge clk)
   begin
      card_io_pin <= io_want;
      card_detect_pin <= (inserted == hi_ins);
   end
endmodule

//--- dv/tb.sv
// self-checking bench of the card pin control block
`timescale 1ns/10ps
module tb;
   logic clk, awready, wready, bvalid, arready, rvalid, io_pin, cd_pin, pow, io_out, ck_en, rst_lv, irq;
   logic nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic inserted = 1'b1, io_want = 1'b0, hi_ins = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [1:0] bresp, rresp, rs;
   int bad_count = 0, comparisons = 0;
   cpcs_top uut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_io_pin(io_pin),
      .card_detect_pin(cd_pin), .card_power_pin(pow), .card_io_out_level(io_out),
      .card_clk_enable(ck_en), .card_reset_level(rst_lv), .irq(irq));
   cpcs_card_model card (.clk(clk), .inserted(inserted), .io_want(io_want), .hi_ins(hi_ins),
      .card_io_pin(io_pin), .card_detect_pin(cd_pin));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic results();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 50)
      begin
         bad_count++;
         $display("[ERR] handshake expected answer seen timeout");
         results();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ready and valid are looked at just after an edge, as they will stand at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic aw_t;
      logic w_t;
      logic b_t;
      logic [1:0] b;
      n = 0;
      b = 2'b11;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         #1;
         aw_t = awready;
         w_t = wready;
         b_t = bvalid;
         if (b_t) b = bresp;
         @(posedge clk);
         n++;
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      while (!b_t && n < 50);
      bready <= 1'b0;
      tmo(n);
      chk("write resp", 32'h0, {30'h0, b});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_t;
      logic r_t;
      n = 0;
      d = 32'h0;
      r = 2'b11;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         #1;
         ar_t = arready;
         r_t = rvalid;
         if (r_t)
         begin
            d = rdata;
            r = rresp;
         end
         @(posedge clk);
         n++;
         if (ar_t) arvalid <= 1'b0;
      end
      while (!r_t && n < 50);
      rready <= 1'b0;
      tmo(n);
   endtask
   // write the pin register, then poll until the sync flag drops
   task automatic wsync(input logic [31:0] d);
      int n;
      wr(8'h24, d);
      n = 0;
      do
      begin
         rd(8'h24, v, rs);
         n++;
      end
      while (v[30] !== 1'b0 && n < 50);
      tmo(n);
   endtask
   task automatic sc_reset();
      rd(8'h24, v, rs);
      chk("pin reg reset", 32'h0, v & 32'hfffe_feef);
      chk("pin reg resp", 32'h0, {30'h0, rs});
   endtask
   task automatic sc_power();
      for (int i = 0; i < 4; i++)
      begin
         wsync({20'h0, i[1], 10'h0, i[0]});
         chk("power pin", {31'h0, i[1] ^ i[0]}, {31'h0, pow});
      end
   endtask
   task automatic sc_reserved();
      wsync(32'hffff_ffff);
      rd(8'h24, v, rs);
      chk("writable bits", 32'h0000_0ec3, v & 32'hbffe_fee3);
      chk("io out level", 32'h1, {31'h0, io_out});
      chk("clk and rst pins", 32'h3, {30'h0, ck_en, rst_lv});
      wsync(32'h0);
   endtask
   task automatic sc_io();
      for (int i = 0; i < 2; i++)
      begin
         io_want <= i[0];
         cyc(4);
         rd(8'h24, v, rs);
         chk("io level", {31'h0, i[0]}, {31'h0, v[16]});
      end
   endtask
   task automatic sc_fall();
      wr(8'h2c, 32'h1);
      inserted <= 1'b0;
      cyc(8);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(8'h24, v, rs);
      chk("removal flag", 32'h4, v & 32'hc);
      inserted <= 1'b1;
      cyc(8);
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(8'h24, v, rs);
      chk("insert flag", 32'h8, v & 32'hc);
      rd(8'h28, v, rs);
      chk("irq status", 32'h3, v & 32'h7);
      cyc(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic sc_rise();
      wsync(32'h400);
      hi_ins <= 1'b1;
      cyc(8);
      rd(8'h24, v, rs);
      chk("insert flag rising", 32'h8, v & 32'hc);
   endtask
   task automatic sc_deact();
      wsync(32'h6c1);
      chk("io out set", 32'h1, {31'h0, io_out});
      chk("clk keep set", 32'h1, {31'h0, ck_en});
      chk("power on", 32'h1, {31'h0, pow});
      rd(8'h28, v, rs);
      wr(8'h2c, 32'h4);
      inserted <= 1'b0;
      cyc(20);
      chk("end irq", 32'h1, {31'h0, irq});
      rd(8'h28, v, rs);
      chk("deact status", 32'h6, v & 32'h6);
      chk("pins after deact", 32'h0, {29'h0, ck_en, io_out, pow});
      rd(8'h24, v, rs);
      chk("bits after deact", 32'h0, v & 32'h243);
   endtask
   task automatic sc_unmapped();
      rd(8'h40, v, rs);
      chk("unmapped resp", 32'h2, {30'h0, rs});
      chk("unmapped data", 32'h0, v);
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      sc_reset();
      sc_power();
      sc_reserved();
      sc_io();
      sc_fall();
      sc_rise();
      sc_deact();
      sc_unmapped();
      results();
   end
endmodule
